// ==== core/dtd_pkg.sv ====
// Constants and types of the decoder core.
// Assumes one 200 MHz clock.
package dtd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_FREQ_MHZ          = 200;
   localparam int CLK_PERIOD_NS         = 5;
   localparam int TONE_PRESENT_TIME_US  = 14000;
   localparam int TONE_ABSENT_TIME_US   = 4000;
   localparam int SETTLE_TIME_NS        = 1000;
   localparam int PRESENT_CYC_DEF       = TONE_PRESENT_TIME_US * CLK_FREQ_MHZ;
   localparam int ABSENT_CYC_DEF        = TONE_ABSENT_TIME_US * CLK_FREQ_MHZ;
   localparam int SETTLE_CYC            =
      (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W               = 24;
   localparam int SETTLE_W              = 8;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [4:0] CTRL_OFS      = 5'h00;
   localparam logic [4:0] STATUS_OFS    = 5'h04;
   localparam logic [4:0] CODE_OFS      = 5'h08;
   localparam logic [4:0] DETECT_OFS    = 5'h0c;
   localparam logic [4:0] COUNT_OFS     = 5'h10;

   // Control fields
   localparam int CTRL_INHIBIT_BIT      = 0;
   localparam int CTRL_PWRDN_BIT        = 1;
   localparam int CTRL_BUSOFF_BIT       = 2;
   localparam logic [2:0] CTRL_RESET    = 3'h0;

   // Status fields (code sits in bits 3..0)
   localparam int STAT_EARLY_BIT        = 4;
   localparam int STAT_DELAYED_BIT      = 5;
   localparam int STAT_STEER_BIT        = 6;
   localparam int STAT_GUARD_BIT        = 7;
   localparam int STAT_PWRDN_BIT        = 8;
   localparam int STAT_NEW_BIT          = 9;
   localparam int STAT_OVERRUN_BIT      = 10;
   localparam int VALID_BIT             = 4;

   localparam logic [3:0]  CODE_RESET   = 4'h0;
   localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Steering state
   typedef enum logic [1:0] {
      STEER_FREE   = 2'b00,
      STEER_SETTLE = 2'b01,
      STEER_HELD   = 2'b10
   } dtd_steer_e;

endpackage

// ==== core/dtd_sync2.sv ====
// Two-stage synchroniser for one level.
// Assumes the input may change at any time relative to CLK.
`timescale 1ns/100ps
`default_nettype none
module dtd_sync2 (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== core/dtd_pair_qual.sv ====
// Tone-pair check, code map and duration qualifier.
// Assumes one-hot group detections.
`timescale 1ns/100ps
`default_nettype none
module dtd_pair_qual
   import dtd_pkg::*;
#(
   parameter int PRESENT_CYC = PRESENT_CYC_DEF,
   parameter int ABSENT_CYC  = ABSENT_CYC_DEF
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       run_en,
   input  wire logic [3:0] low_grp,
   input  wire logic [3:0] high_grp,
   input  wire logic       inhibit,
   output logic            raw_valid,
   output logic [3:0]      raw_code,
   output logic            sig_cond,
   output logic [3:0]      cond_code
);
   logic [TIMER_W-1:0] timer_r;
   logic [3:0]         cand_r;
   logic [3:0]         high_m;

   function automatic logic onehot4(input logic [3:0] v);
      return (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
   endfunction

   function automatic logic [1:0] idx4(input logic [3:0] v);
      return v[3] ? 2'd3 : v[2] ? 2'd2 : v[1] ? 2'd1 : 2'd0;
   endfunction

   // Row and column to output code
   function automatic logic [3:0] key_code(input logic [1:0] row,
                                           input logic [1:0] col);
      logic [3:0] c;
      c = 4'h0;
      if (col == 2'd3) begin
         c = (row == 2'd3) ? 4'h0 : 4'(4'hd + {2'b00, row});
      end else if (row == 2'd3) begin
         unique case (col)
            2'd0:    c = 4'hb;
            2'd1:    c = 4'ha;
            default: c = 4'hc;
         endcase
      end else begin
         c = 4'(row * 3 + col + 1);
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Frequency check, inhibit masks the top high tone
   assign high_m    = inhibit ? {1'b0, high_grp[2:0]} : high_grp; // [RULE_12]
   assign raw_valid = onehot4(low_grp) && onehot4(high_m) &&
                      !(inhibit && high_grp[3]); // [RULE_19]
   assign raw_code  = key_code(idx4(low_grp), idx4(high_m)); // [RULE_16]

   ////////////////////////////////////////////////////////////////////////
   // Duration: present time to raise, absent time to drop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timer_r   <= '0;
         cand_r    <= CODE_RESET;
         sig_cond  <= 1'b0;
         cond_code <= CODE_RESET;
      end else if (run_en) begin
         if (!sig_cond) begin
            if (raw_valid && raw_code == cand_r && timer_r != '0) begin
               if (timer_r >= TIMER_W'(PRESENT_CYC - 1)) begin
                  sig_cond  <= 1'b1; // [RULE_14]
                  cond_code <= cand_r; // [RULE_01]
                  timer_r   <= '0;
               end else begin
                  timer_r <= timer_r + 1'b1; // [RULE_20]
               end
            end else if (raw_valid) begin
               cand_r  <= raw_code;
               timer_r <= TIMER_W'(1); // [RULE_02]
            end else begin
               timer_r <= '0;
            end
         end else begin
            if (raw_valid && raw_code == cond_code) begin
               timer_r <= '0;
            end else if (timer_r >= TIMER_W'(ABSENT_CYC - 1)) begin
               sig_cond <= 1'b0; // [RULE_15]
               timer_r  <= '0;
               cand_r   <= raw_code;
            end else begin
               timer_r <= timer_r + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== core/dtd_decoder.sv ====
// Decoder top: steering, latch, guard pin, bus.
// Assumes synchronous pins and an Avalon-MM master.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RULE_01 - All sixteen tone pairs give a distinct four-bit code.
// RULE_02 - Pair is checked for frequency and duration before reaching the bus.
// RULE_03 - Code pins driven only while output enable high; pulled up at pin.
// RULE_04 - Code pins show latched code of last registered pair.
// RULE_05 - Delayed flag rises once a pair is registered and latched.
// RULE_06 - Delayed flag falls when steering input drops below threshold.
// RULE_07 - Early flag rises as soon as signal condition is detected.
// RULE_08 - Loss of signal condition drops early flag at once.
// RULE_09 - Steering input rising registers current pair into latch.
// RULE_10 - Steering input low frees the device to take a new pair.
// RULE_11 - Guard output resets the RC; depends on early flag and steering.
// RULE_12 - Inhibit high suppresses the 1633 Hz tone; default off.
// RULE_13 - Power-down high stops all timing; default running.
// RULE_14 - Signal condition rises after tone present time, 14 ms typical.
// RULE_15 - Signal condition drops after tone absent time, 4 ms typical.
// RULE_16 - Keys 1-9 binary, 0=1010, *=1011, #=1100, A-C=1101-1111, D=0000.
// RULE_17 - After registration guard drives high while early flag high.
// RULE_18 - Delayed flag rises a settle delay after latch update.
// RULE_19 - Under inhibit, an inhibited pair leaves the latched code unchanged.
// RULE_20 - Timers count clock cycles; steering level is synchronised.
module dtd_decoder
   import dtd_pkg::*;
#(
   parameter int PRESENT_CYC = PRESENT_CYC_DEF,
   parameter int ABSENT_CYC  = ABSENT_CYC_DEF
) (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic [3:0]  LOW_GROUP,
   input  wire logic [3:0]  HIGH_GROUP,
   input  wire logic        HIGH_TONE_INHIBIT,
   input  wire logic        POWER_DOWN_INPUT,
   input  wire logic        CODE_OUTPUT_ENABLE,
   output logic             CODE_BIT0,
   output logic             CODE_BIT1,
   output logic             CODE_BIT2,
   output logic             CODE_BIT3,
   output logic             CODE_BIT_OE,
   output logic             EARLY_STEERING_FLAG,
   output logic             DELAYED_STEERING_FLAG,
   input  wire logic        STEER_IN,
   output logic             GUARD_OUT,
   output logic             GUARD_OE,
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [2:0]          ctrl_r;
   logic                inhibit;
   logic                pwrdn;
   logic                run_en;

   logic                steer_sync;
   logic                steer_d_r;
   logic                steer_rise;

   logic                raw_valid;
   logic [3:0]          raw_code;
   logic                sig_cond;
   logic [3:0]          cond_code;

   dtd_steer_e          state_r;
   logic [SETTLE_W-1:0] settle_r;

   logic [3:0]          code_latch_r;
   logic                latch_load;

   logic                new_r;
   logic                overrun_r;
   logic [15:0]         count_r;

   logic                bus_acc;
   logic                wr_acc;
   logic                rd_acc;
   logic                code_rd;
   logic                count_clr;
   logic [31:0]         rdata_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Mode inputs, pins and control register combined
   assign inhibit = HIGH_TONE_INHIBIT | ctrl_r[CTRL_INHIBIT_BIT]; // [RULE_12]
   assign pwrdn   = POWER_DOWN_INPUT | ctrl_r[CTRL_PWRDN_BIT];
   assign run_en  = !pwrdn; // [RULE_13]

   ////////////////////////////////////////////////////////////////////////
   // Steering level synchroniser and edge
   dtd_sync2 u_steer_sync (
      .clk  (CLK),
      .nrst (NRST),
      .d    (STEER_IN),
      .q    (steer_sync)
   ); // [RULE_20]

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         steer_d_r <= 1'b0;
      end else if (run_en) begin
         steer_d_r <= steer_sync;
      end
   end

   assign steer_rise = steer_sync && !steer_d_r;

   ////////////////////////////////////////////////////////////////////////
   // Tone pair qualification
   dtd_pair_qual #(
      .PRESENT_CYC (PRESENT_CYC),
      .ABSENT_CYC  (ABSENT_CYC)
   ) u_qual (
      .clk       (CLK),
      .nrst      (NRST),
      .run_en    (run_en),
      .low_grp   (LOW_GROUP),
      .high_grp  (HIGH_GROUP),
      .inhibit   (inhibit),
      .raw_valid (raw_valid),
      .raw_code  (raw_code),
      .sig_cond  (sig_cond),
      .cond_code (cond_code)
   );

   ////////////////////////////////////////////////////////////////////////
   // Early steering flag
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         EARLY_STEERING_FLAG <= 1'b0;
      end else if (run_en) begin
         EARLY_STEERING_FLAG <= sig_cond; // [RULE_07] [RULE_08]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Steering state machine
   assign latch_load = run_en && (state_r == STEER_FREE) &&
                       steer_rise && sig_cond; // [RULE_09] [RULE_10]

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_r  <= STEER_FREE;
         settle_r <= '0;
      end else if (run_en) begin
         unique case (state_r)
            STEER_FREE: begin
               settle_r <= '0;
               if (latch_load) begin
                  state_r <= STEER_SETTLE;
               end
            end

            STEER_SETTLE: begin
               if (!steer_sync) begin
                  state_r <= STEER_FREE;
               end else if (settle_r >= SETTLE_W'(SETTLE_CYC - 1)) begin
                  state_r <= STEER_HELD; // [RULE_18]
               end else begin
                  settle_r <= settle_r + 1'b1;
               end
            end

            STEER_HELD: begin
               if (!steer_sync) begin
                  state_r <= STEER_FREE;
               end
            end
            default: begin
               state_r <= STEER_FREE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         DELAYED_STEERING_FLAG <= 1'b0;
      end else if (run_en) begin
         if (!steer_sync) begin
            DELAYED_STEERING_FLAG <= 1'b0; // [RULE_06]
         end else if (state_r == STEER_SETTLE &&
                      settle_r >= SETTLE_W'(SETTLE_CYC - 1)) begin
            DELAYED_STEERING_FLAG <= 1'b1; // [RULE_05]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output latch
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         code_latch_r <= CODE_RESET;
      end else if (latch_load) begin
         code_latch_r <= cond_code; // [RULE_04] [RULE_19]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Code pins and their enable
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         CODE_BIT0   <= 1'b0;
         CODE_BIT1   <= 1'b0;
         CODE_BIT2   <= 1'b0;
         CODE_BIT3   <= 1'b0;
         CODE_BIT_OE <= 1'b0;
      end else begin
         CODE_BIT0   <= code_latch_r[0];
         CODE_BIT1   <= code_latch_r[1];
         CODE_BIT2   <= code_latch_r[2];
         CODE_BIT3   <= code_latch_r[3];
         CODE_BIT_OE <= CODE_OUTPUT_ENABLE &&
                        !ctrl_r[CTRL_BUSOFF_BIT]; // [RULE_03]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Guard time output
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         GUARD_OUT <= 1'b0;
         GUARD_OE  <= 1'b0;
      end else if (run_en) begin
         GUARD_OUT <= sig_cond && steer_sync; // [RULE_17]
         GUARD_OE  <= (sig_cond == steer_sync); // [RULE_11]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign bus_acc   = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   assign wr_acc    = AVS_WRITE && !AVS_WAITREQUEST;
   assign rd_acc    = AVS_READ && !AVS_WAITREQUEST;
   assign code_rd   = rd_acc && (AVS_ADDRESS == CODE_OFS);
   assign count_clr = wr_acc && (AVS_ADDRESS == COUNT_OFS) &&
                      (AVS_BYTEENABLE != 4'h0);

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_acc && AVS_ADDRESS == CTRL_OFS &&
                   AVS_BYTEENABLE[0]) begin
         ctrl_r <= AVS_WRITEDATA[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // New code and overrun flags, set wins over read clear for new, read clear wins for overrun
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         new_r     <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         if (latch_load) begin
            new_r <= 1'b1;
         end else if (code_rd) begin
            new_r <= 1'b0;
         end
         if (latch_load && new_r && !code_rd) begin
            overrun_r <= 1'b1;
         end else if (code_rd) begin
            overrun_r <= 1'b0;
         end
      end
   end

   // Registration counter, load and clear in the same cycle give a count of one
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         count_r <= 16'h0000;
      end else if (latch_load) begin
         count_r <= count_clr ? 16'h0001 : count_r + 1'b1;
      end else if (count_clr) begin
         count_r <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      rdata_nxt = READ_ZERO;
      unique case (AVS_ADDRESS)
         CTRL_OFS: begin
            rdata_nxt[2:0] = ctrl_r;
         end

         STATUS_OFS: begin
            rdata_nxt[3:0]              = code_latch_r;
            rdata_nxt[STAT_EARLY_BIT]   = EARLY_STEERING_FLAG;
            rdata_nxt[STAT_DELAYED_BIT] = DELAYED_STEERING_FLAG;
            rdata_nxt[STAT_STEER_BIT]   = steer_sync;
            rdata_nxt[STAT_GUARD_BIT]   = GUARD_OUT;
            rdata_nxt[STAT_PWRDN_BIT]   = pwrdn;
            rdata_nxt[STAT_NEW_BIT]     = new_r;
            rdata_nxt[STAT_OVERRUN_BIT] = overrun_r;
         end

         CODE_OFS: begin
            rdata_nxt[3:0]       = code_latch_r;
            rdata_nxt[VALID_BIT] = new_r;
         end

         DETECT_OFS: begin
            rdata_nxt[3:0]       = raw_code;
            rdata_nxt[VALID_BIT] = raw_valid;
         end

         COUNT_OFS: begin
            rdata_nxt[15:0] = count_r;
         end
         default: begin
            rdata_nxt = READ_ZERO;
         end
      endcase
   end

   // One wait cycle, then one answer cycle
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= READ_ZERO;
      end else begin
         if (bus_acc) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= AVS_READ ? rdata_nxt : READ_ZERO;
         end else begin
            AVS_WAITREQUEST <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ==== verif/dtd_decoder_properties.sv ====
// Checker of the decoder top ports.
// Assumes a bind into dtd_decoder.
`timescale 1ns/100ps
`default_nettype none
module dtd_decoder_properties #(
   parameter int PRESENT_CYC = 20,
   parameter int ABSENT_CYC  = 10
) (
   input wire logic       CLK,
   input wire logic       NRST,
   input wire logic [3:0] LOW_GROUP,
   input wire logic [3:0] HIGH_GROUP,
   input wire logic       POWER_DOWN_INPUT,
   input wire logic       CODE_OUTPUT_ENABLE,
   input wire logic       CODE_BIT0,
   input wire logic       CODE_BIT1,
   input wire logic       CODE_BIT2,
   input wire logic       CODE_BIT3,
   input wire logic       CODE_BIT_OE,
   input wire logic       EARLY_STEERING_FLAG,
   input wire logic       DELAYED_STEERING_FLAG,
   input wire logic       STEER_IN,
   input wire logic       GUARD_OUT,
   input wire logic       GUARD_OE,
   input wire logic       AVS_READ,
   input wire logic       AVS_WRITE,
   input wire logic       AVS_WAITREQUEST
);
   logic [3:0] code, low_r, high_r;
   logic       pair;
   int         stab_cnt, miss_cnt;
   assign code = {CODE_BIT3, CODE_BIT2, CODE_BIT1, CODE_BIT0};
   assign pair = $onehot(LOW_GROUP) && $onehot(HIGH_GROUP);
   // Stable-pair and no-pair cycle counts
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         low_r    <= 4'h0;
         high_r   <= 4'h0;
         stab_cnt <= 0;
         miss_cnt <= 0;
      end else begin
         low_r    <= LOW_GROUP;
         high_r   <= HIGH_GROUP;
         if (!pair)
            stab_cnt <= 0;
         else if (LOW_GROUP != low_r || HIGH_GROUP != high_r)
            stab_cnt <= 1;
         else if (stab_cnt < 1000)
            stab_cnt <= stab_cnt + 1;
         miss_cnt <= pair ? 0 : (miss_cnt < 1000 ? miss_cnt + 1 : miss_cnt);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_oe_follow: assert property (
      $changed(CODE_OUTPUT_ENABLE)
      |=> CODE_BIT_OE == $past(CODE_OUTPUT_ENABLE))
      else $error("code enable not followed");
   a_bus_answer: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus not answered");
   a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("wait low too long");
   a_early_time: assert property (
      $rose(EARLY_STEERING_FLAG) |-> stab_cnt >= PRESENT_CYC)
      else $error("early flag too soon");
   a_early_drop: assert property (
      disable iff (!NRST || POWER_DOWN_INPUT)
      miss_cnt > ABSENT_CYC + 2 |-> !EARLY_STEERING_FLAG)
      else $error("early flag kept");
   a_delayed_drop: assert property (
      disable iff (!NRST || POWER_DOWN_INPUT)
      !STEER_IN [*5] |-> !DELAYED_STEERING_FLAG)
      else $error("delayed flag kept");
   a_settle_first: assert property (
      $rose(DELAYED_STEERING_FLAG)
      |-> code == $past(code, 100) && $past(STEER_IN, 100))
      else $error("delayed flag too soon");
   a_guard_level: assert property (
      GUARD_OE |-> GUARD_OUT == EARLY_STEERING_FLAG)
      else $error("guard level wrong");
   a_code_hold: assert property (
      $changed(code) |-> $past(STEER_IN, 2))
      else $error("code changed unsteered");
endmodule
`default_nettype wire

// ==== verif/dtd_host_model.sv ====
// Host: RC steering node and code reader.
// Assumes the driven guard pin overrides the node.
`timescale 1ns/100ps
`default_nettype none
module dtd_host_model #(
   parameter int CAP = 16
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       early,
   input  wire logic       guard_out,
   input  wire logic       guard_oe,
   input  wire logic       delayed,
   input  wire logic [3:0] bits,
   input  wire logic       oe,
   output logic            steer,
   output logic [3:0]      got_code
);
   int         cap_r;
   logic       del_r;
   logic [3:0] last_r;
   // RC node
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         cap_r <= 0;
      else if (guard_oe)
         cap_r <= guard_out ? CAP : 0;
      else if (early)
         cap_r <= cap_r < CAP ? cap_r + 1 : CAP;
      else
         cap_r <= cap_r > 0 ? cap_r - 1 : 0;
   end
   assign steer = cap_r >= CAP / 2;
   // Code read; floating pins read inverted
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         del_r    <= 1'h0;
         last_r   <= 4'h0;
         got_code <= 4'h0;
      end else begin
         del_r  <= delayed;
         last_r <= oe ? bits : last_r;
         if (delayed && !del_r)
            got_code <= oe ? bits : ~last_r;
      end
   end
endmodule
`default_nettype wire

// ==== verif/dtd_decoder_tb.sv ====
// Decoder bench: keys, steering, modes, bus.
// Assumes the host model drives steering.
`timescale 1ns/100ps
`default_nettype none
module dtd_decoder_tb
   import dtd_pkg::*;
;
   localparam int P = 20;
   localparam int A = 10;
   logic        CLK = 1'h0, NRST = 1'h0;
   logic [3:0]  LOW_GROUP = 4'h0, HIGH_GROUP = 4'h0, AVS_BYTEENABLE = 4'hf;
   logic        HIGH_TONE_INHIBIT = 1'h0; // Pull-down
   logic        POWER_DOWN_INPUT = 1'h0; // Pull-down
   logic        CODE_OUTPUT_ENABLE = 1'h1; // Pull-up
   logic        AVS_READ = 1'h0, AVS_WRITE = 1'h0;
   logic [4:0]  AVS_ADDRESS = 5'h00;
   logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA, q;
   logic        CODE_BIT0, CODE_BIT1, CODE_BIT2, CODE_BIT3, CODE_BIT_OE;
   logic        EARLY_STEERING_FLAG, DELAYED_STEERING_FLAG, STEER_IN;
   logic        GUARD_OUT, GUARD_OE, AVS_WAITREQUEST;
   logic [3:0]  got;
   int          err_total = 0, comparisons = 0;
   wire logic [3:0] pins = {CODE_BIT3, CODE_BIT2, CODE_BIT1, CODE_BIT0};
   wire logic [1:0] flags = {DELAYED_STEERING_FLAG, EARLY_STEERING_FLAG};
   always #2.5 CLK = ~CLK;
   dtd_decoder #(.PRESENT_CYC(P), .ABSENT_CYC(A)) u_dut (.*);
   dtd_host_model u_host (.clk(CLK), .nrst(NRST),
      .early(EARLY_STEERING_FLAG), .guard_out(GUARD_OUT),
      .guard_oe(GUARD_OE), .delayed(DELAYED_STEERING_FLAG), .bits(pins),
      .oe(CODE_BIT_OE), .steer(STEER_IN), .got_code(got));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int n = 0;
      AVS_ADDRESS    <= a;
      AVS_WRITEDATA  <= d;
      AVS_BYTEENABLE <= be;
      AVS_WRITE      <= w;
      AVS_READ       <= !w;
      do begin
         @(posedge CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'h0 && n < 20);
      q = AVS_READDATA;
      chk("wait", 0, AVS_WAITREQUEST);
      AVS_READ  <= 1'h0;
      AVS_WRITE <= 1'h0;
      @(posedge CLK);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, string s);
      bus(1'h0, a, 32'h0000_0000, 4'hf);
      chk(s, e, q);
   endtask
   task automatic wt(input int i, input logic v);
      int n = 0;
      while (flags[i] !== v && n < 1000) begin
         @(posedge CLK);
         n++;
      end
      chk("flag", v, flags[i]);
   endtask
   task automatic tone(input int l, h);
      LOW_GROUP  <= 4'h1 << l;
      HIGH_GROUP <= 4'h1 << h;
   endtask
   function automatic logic [3:0] key_code(input int l, h);
      if (h == 3)
         return l == 3 ? 4'h0 : 4'hd + 4'(l);
      if (l == 3)
         return h == 0 ? 4'hb : (h == 1 ? 4'ha : 4'hc);
      return 4'(l * 3 + h + 1);
   endfunction
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge CLK);
      chk("reset wait", 1, AVS_WAITREQUEST);
      chk("reset outs", 0, {GUARD_OE, GUARD_OUT, flags, CODE_BIT_OE, pins});
      NRST <= 1'h1;
      @(posedge CLK);
      tone(0, 0);
      repeat (P / 2) @(posedge CLK);
      tone(4, 4);
      repeat (3 * P) @(posedge CLK);
      rd(COUNT_OFS, 0, "burst");
      for (int l = 0; l < 4; l++) begin
         for (int h = 0; h < 4; h++) begin
            tone(l, h);
            wt(1, 1'h1);
            chk("code pins", key_code(l, h), pins);
            chk("guard", 2'h3, {GUARD_OE, GUARD_OUT});
            tone(4, 4);
            repeat (3) @(posedge CLK);
            tone(l, h);
            repeat (2 * A) @(posedge CLK);
            chk("dropout", 1, EARLY_STEERING_FLAG);
            tone(4, 4);
            wt(0, 1'h0);
            wt(1, 1'h0);
            chk("host code", key_code(l, h), got);
         end
      end
      rd(COUNT_OFS, 16, "keys");
      rd(CODE_OFS, 32'h0000_0010, "code new");
      rd(CODE_OFS, 32'h0000_0000, "code clr");
      HIGH_TONE_INHIBIT <= 1'h1;
      tone(0, 3);
      repeat (3 * P) @(posedge CLK);
      chk("inh early", 0, EARLY_STEERING_FLAG);
      chk("inh code", 0, pins);
      tone(0, 0);
      wt(1, 1'h1);
      chk("inh key", 1, pins);
      rd(STATUS_OFS, 32'h0000_02f1, "status");
      tone(4, 4);
      wt(1, 1'h0);
      HIGH_TONE_INHIBIT <= 1'h0;
      bus(1'h1, CTRL_OFS, 32'h0000_0005, 4'h0);
      rd(CTRL_OFS, 0, "ctrl be0");
      bus(1'h1, CTRL_OFS, 32'h0000_0005, 4'hf);
      rd(CTRL_OFS, 5, "ctrl");
      chk("forced off", 0, CODE_BIT_OE);
      tone(1, 3);
      repeat (3 * P) @(posedge CLK);
      chk("sw inh", 0, EARLY_STEERING_FLAG);
      tone(4, 4);
      bus(1'h1, CTRL_OFS, 32'h0000_0000, 4'hf);
      POWER_DOWN_INPUT <= 1'h1;
      tone(2, 2);
      repeat (3 * P) @(posedge CLK);
      chk("pd early", 0, EARLY_STEERING_FLAG);
      rd(DETECT_OFS, 32'h0000_0019, "detect");
      tone(4, 4);
      repeat (2) @(posedge CLK);
      POWER_DOWN_INPUT   <= 1'h0;
      CODE_OUTPUT_ENABLE <= 1'h0;
      repeat (3) @(posedge CLK);
      chk("bus off", 0, CODE_BIT_OE);
      CODE_OUTPUT_ENABLE <= 1'h1;
      repeat (3) @(posedge CLK);
      chk("bus on", 1, CODE_BIT_OE);
      rd(5'h14, 0, "unmapped");
      bus(1'h1, COUNT_OFS, 32'h0000_0000, 4'hf);
      rd(COUNT_OFS, 0, "cnt clr");
      final_report;
   end
   initial begin
      repeat (40000) @(posedge CLK);
      err_total++;
      $display("wrong value watchdog expected done seen running");
      final_report;
   end
endmodule
bind dtd_decoder dtd_decoder_properties #(.PRESENT_CYC(PRESENT_CYC),
   .ABSENT_CYC(ABSENT_CYC)) u_chk (.*);
`default_nettype wire
